/* verilog/gco_regs.sv */
// How it works
// - gain code in bits 3-0 scales output samples
// - one dB per code, 0 to 11 dB
// - estimate-source bit selects external offset estimate, channel a only
// - control pattern 111 freezes the offset estimate
// - bypass bit passes samples uncorrected
// - active corrector removes fs/8, fs/4, 3fs/8, fs/2 tones
// - each channel has its own control register

`timescale 1ns/10ps
`include "gco_params.svh"

module gco_regs (
  input wire logic CLK, // sample clock, 10 MHz
  input wire logic RST, // synchronous reset, high
  input wire logic [8:0] ADDR, // register address
  input wire logic [7:0] WDATA, // write data
  input wire logic WR, // write strobe, one cycle
  input wire logic RD, // read strobe, one cycle
  output logic [7:0] RDATA, // read data, cycle after RD
  input wire gco_pkg::gco_sample_t SAMPLE_A, // raw sample, channel a
  input wire gco_pkg::gco_sample_t SAMPLE_B, // raw sample, channel b
  input wire gco_pkg::gco_sample_t EXT_EST, // external offset estimate, channel a
  output gco_pkg::gco_sample_t DOUT_A, // corrected and gained, channel a
  output gco_pkg::gco_sample_t DOUT_B // corrected and gained, channel b
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  gco_pkg::gco_regs_state_t cur_ff; // all state of the bank
  gco_pkg::gco_regs_state_t nxt_cur; // its next value
  gco_pkg::gco_sample_t corr [2]; // corrector outputs per channel
  gco_pkg::gco_sample_t raw [2]; // raw inputs per channel
  logic [1:0] freeze; // decoded freeze per channel
  logic [1:0] bypass; // decoded bypass per channel

  assign raw[0] = SAMPLE_A;
  assign raw[1] = SAMPLE_B;

  // ----------------------------------------
  // gain table
  // ----------------------------------------
  // q2.14 factors of 10^(dB/20); undefined codes fall back to unity
  function automatic logic signed [16:0] gain_factor(input logic [3:0] code);
    case (code)
      4'h0: gain_factor = 17'sh04000;
      4'h1: gain_factor = 17'sh047cf;
      4'h2: gain_factor = 17'sh05092;
      4'h3: gain_factor = 17'sh05a67;
      4'h4: gain_factor = 17'sh0656f;
      4'h5: gain_factor = 17'sh071cf;
      4'h6: gain_factor = 17'sh07fb2;
      4'h7: gain_factor = 17'sh08f47;
      4'h8: gain_factor = 17'sh0a0c2;
      4'h9: gain_factor = 17'sh0b45f;
      4'ha: gain_factor = 17'sh0ca62;
      4'hb: gain_factor = `GCO_GAIN_TOP;
      default: gain_factor = 17'sh04000;
    endcase
  endfunction : gain_factor

  // ----------------------------------------
  // per-channel correctors
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      // mode bits are {7,5,1}; only 111 freezes, the rest estimate
      assign freeze[ch] = ({cur_ff.ctrl[ch][3], cur_ff.ctrl[ch][2], cur_ff.ctrl[ch][0]} == `GCO_MODE_FREEZE);
      assign bypass[ch] = cur_ff.ctrl[ch][1];
      gco_dc_corr u_corr (
        .clk(CLK),
        .rst(RST),
        .sample_in(raw[ch]),
        .ext_est(EXT_EST),
        .use_ext((ch == 0) ? cur_ff.est_src : 1'b0),
        .freeze(freeze[ch]),
        .bypass(bypass[ch]),
        .sample_out(corr[ch])
      );
    end
  endgenerate

  // ----------------------------------------
  // register access and gain stage
  // ----------------------------------------
  // reads answer the cycle after RD only; otherwise RDATA rests at zero
  always_comb begin
    logic signed [33:0] prod;
    prod = 34'sh0;
    nxt_cur = cur_ff;
    nxt_cur.rdata = `GCO_RESET_BYTE;
    // writes: only defined fields are kept, reserved bits are dropped
    if (WR) begin
      case (ADDR)
        `GCO_ADDR_GAIN: begin
          nxt_cur.gain = WDATA[`GCO_GAIN_MSB:`GCO_GAIN_LSB];
        end
        `GCO_ADDR_EST_SRC_A: begin
          nxt_cur.est_src = WDATA[`GCO_EST_SRC_BIT];
        end
        `GCO_ADDR_CTRL_A: begin
          nxt_cur.ctrl[0] = {WDATA[`GCO_CTRL_FREEZE_BIT], WDATA[`GCO_CTRL_KEEP_HI_BIT],
                             WDATA[`GCO_CTRL_BYPASS_BIT], WDATA[`GCO_CTRL_KEEP_LO_BIT]};
        end
        `GCO_ADDR_CTRL_B: begin
          nxt_cur.ctrl[1] = {WDATA[`GCO_CTRL_FREEZE_BIT], WDATA[`GCO_CTRL_KEEP_HI_BIT],
                             WDATA[`GCO_CTRL_BYPASS_BIT], WDATA[`GCO_CTRL_KEEP_LO_BIT]};
        end
        default: begin
          // unmapped or read-only address: write ignored
        end
      endcase
    end
    // reads: fields back in their own bit positions, reserved read zero
    if (RD) begin
      case (ADDR)
        `GCO_ADDR_GAIN: begin
          nxt_cur.rdata = {4'h0, cur_ff.gain};
        end
        `GCO_ADDR_EST_SRC_A: begin
          nxt_cur.rdata = {7'h00, cur_ff.est_src};
        end
        `GCO_ADDR_CTRL_A: begin
          nxt_cur.rdata = {cur_ff.ctrl[0][3], 1'b0, cur_ff.ctrl[0][2], 2'h0,
                           cur_ff.ctrl[0][1], cur_ff.ctrl[0][0], 1'b0};
        end
        `GCO_ADDR_CTRL_B: begin
          nxt_cur.rdata = {cur_ff.ctrl[1][3], 1'b0, cur_ff.ctrl[1][2], 2'h0,
                           cur_ff.ctrl[1][1], cur_ff.ctrl[1][0], 1'b0};
        end
        `GCO_ADDR_STATUS: begin
          // live decoded modes: {freeze_b, freeze_a, bypass_b, bypass_a}
          nxt_cur.rdata = {4'h0, freeze, bypass};
        end
        default: begin
          nxt_cur.rdata = `GCO_RESET_BYTE; // unmapped reads zero
        end
      endcase
    end
    // gain on both channels; saturates rather than wraps at high codes
    for (int i = 0; i < 2; i++) begin
      prod = 34'(corr[i]) * 34'(gain_factor(cur_ff.gain));
      nxt_cur.dout[i] = gco_pkg::gco_sat16(prod >>> `GCO_GAIN_FRAC);
    end
  end

  // state register; synchronous reset clears every field
  always_ff @(posedge CLK) begin
    if (RST) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from flip-flops
  assign RDATA = cur_ff.rdata;
  assign DOUT_A = cur_ff.dout[0];
  assign DOUT_B = cur_ff.dout[1];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_gain_unity: assert property (@(posedge CLK) disable iff (RST)
    (cur_ff.gain == 4'h0) |=> DOUT_A == $past(corr[0]) && DOUT_B == $past(corr[1]))
    else $error("zero gain code altered samples");

  a_gain_top: assert property (@(posedge CLK) disable iff (RST)
    (cur_ff.gain == `GCO_GAIN_MAX_CODE) |=>
      DOUT_A == gco_pkg::gco_sat16((34'($past(corr[0])) * 34'(`GCO_GAIN_TOP)) >>> `GCO_GAIN_FRAC))
    else $error("top gain code wrong");

  a_ctrl_indep: assert property (@(posedge CLK) disable iff (RST)
    (WR && ADDR == `GCO_ADDR_CTRL_A) |=> cur_ff.ctrl[1] == $past(cur_ff.ctrl[1]))
    else $error("channel a write touched channel b");

  a_read_gain: assert property (@(posedge CLK) disable iff (RST)
    (RD && !WR && ADDR == `GCO_ADDR_GAIN) |=> RDATA == {4'h0, $past(cur_ff.gain)} ##1 RDATA == 8'h00 || $past(RD))
    else $error("gain readback wrong");

endmodule : gco_regs

/* common/gco_params.svh */
`ifndef GCO_PARAMS_SVH
`define GCO_PARAMS_SVH

// ----------------------------------------
// register offsets on the plain port
// ----------------------------------------
`define GCO_ADDR_EST_SRC_A 9'h034
`define GCO_ADDR_CTRL_A 9'h068
`define GCO_ADDR_CTRL_B 9'h168
`define GCO_ADDR_GAIN 9'h0a6
`define GCO_ADDR_STATUS 9'h0f0

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define GCO_GAIN_LSB 0
`define GCO_GAIN_MSB 3
`define GCO_EST_SRC_BIT 0
`define GCO_CTRL_FREEZE_BIT 7
`define GCO_CTRL_KEEP_HI_BIT 5
`define GCO_CTRL_BYPASS_BIT 2
`define GCO_CTRL_KEEP_LO_BIT 1
`define GCO_RESET_BYTE 8'h00
`define GCO_MODE_RUN 3'h3
`define GCO_MODE_FREEZE 3'h7
`define GCO_GAIN_MAX_CODE 4'hb

// ----------------------------------------
// datapath scaling
// ----------------------------------------
`define GCO_EST_SHIFT 6
`define GCO_GAIN_FRAC 14
`define GCO_GAIN_TOP 17'sh0e315

`endif

/* common/gco_pkg.sv */
package gco_pkg;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef logic signed [15:0] gco_sample_t; // one converter sample

  // state of one channel's offset corrector
  typedef struct packed {
    logic [2:0] phase; // sample phase mod 8
    logic [7:0][23:0] acc; // per-phase estimate, 16.8 fixed point
    logic [15:0] out; // corrected sample
  } gco_corr_state_t;

  // state of the register bank and gain stage
  typedef struct packed {
    logic [3:0] gain; // output gain code
    logic est_src; // external estimate select, channel a
    logic [1:0][3:0] ctrl; // per channel {freeze, keep_hi, bypass, keep_lo}
    logic [7:0] rdata; // read answer
    logic [1:0][15:0] dout; // gained samples
  } gco_regs_state_t;

  // saturate a wide signed value to one sample
  function automatic logic [15:0] gco_sat16(input logic signed [33:0] v);
    if (v > 34'sh0_0000_7fff) begin
      return 16'h7fff;
    end
    if (v < 34'sh3_ffff_8000) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction : gco_sat16

endpackage : gco_pkg

/* verilog/gco_dc_corr.sv */
`timescale 1ns/10ps
`include "gco_params.svh"

module gco_dc_corr (
  input wire logic clk, // sample clock
  input wire logic rst, // synchronous reset, high
  input wire gco_pkg::gco_sample_t sample_in, // raw sample
  input wire gco_pkg::gco_sample_t ext_est, // externally supplied offset
  input wire logic use_ext, // take ext_est instead of own estimate
  input wire logic freeze, // hold estimates, keep applying them
  input wire logic bypass, // pass samples uncorrected
  output gco_pkg::gco_sample_t sample_out // corrected sample, registered
);

  gco_pkg::gco_corr_state_t cur_ff; // all state
  gco_pkg::gco_corr_state_t nxt_cur; // its next value

  // ----------------------------------------
  // estimator and subtractor
  // ----------------------------------------
  // one estimate per phase mod 8 removes tones at fs/8, fs/4, 3fs/8, fs/2
  always_comb begin
    logic signed [23:0] acc_sel;
    logic signed [15:0] est;
    logic signed [24:0] diff;
    acc_sel = cur_ff.acc[cur_ff.phase];
    est = use_ext ? ext_est : acc_sel[23:8];
    diff = 25'sh0;
    nxt_cur = cur_ff;
    nxt_cur.phase = cur_ff.phase + 3'h1;
    if (bypass) begin
      // estimates are held so re-enabling resumes from known values
      nxt_cur.out = sample_in;
    end else begin
      nxt_cur.out = gco_pkg::gco_sat16(34'(sample_in) - 34'(est));
      if (!freeze) begin
        // leaky average; shift trades settling time for noise
        diff = $signed({sample_in[15], sample_in, 8'h00}) - $signed({acc_sel[23], acc_sel});
        nxt_cur.acc[cur_ff.phase] = acc_sel + 24'(diff >>> `GCO_EST_SHIFT);
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign sample_out = cur_ff.out;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_bypass_pass: assert property (@(posedge clk) disable iff (rst)
    bypass |=> sample_out == $past(sample_in)) else $error("bypass did not pass sample");

  a_ext_estimate: assert property (@(posedge clk) disable iff (rst)
    (use_ext && !bypass) |=> sample_out == gco_pkg::gco_sat16(34'($past(sample_in)) - 34'($past(ext_est))))
    else $error("external estimate not applied");

  a_freeze_holds: assert property (@(posedge clk) disable iff (rst)
    (freeze || bypass) |=> cur_ff.acc == $past(cur_ff.acc)) else $error("estimate moved while frozen");

  a_phase_walk: assert property (@(posedge clk) disable iff (rst)
    $past(!rst) |-> cur_ff.phase == 3'($past(cur_ff.phase) + 3'h1)) else $error("phase did not advance");

endmodule : gco_dc_corr

/* verif/tb.sv */
`timescale 1ns/10ps
`include "gco_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic CLK = 1'b0; // 10 MHz sample clock
  logic RST = 1'b1; // synchronous reset, high
  logic [8:0] ADDR = 9'h000; // register address
  logic [7:0] WDATA = 8'h00; // write data
  logic WR = 1'b0; // write strobe
  logic RD = 1'b0; // read strobe
  gco_pkg::gco_sample_t SA = 16'sh0000; // raw sample a
  gco_pkg::gco_sample_t SB = 16'sh0000; // raw sample b
  gco_pkg::gco_sample_t EE = 16'sh0000; // external estimate
  logic [7:0] RDATA; // read answer
  gco_pkg::gco_sample_t DOUT_A; // output a
  gco_pkg::gco_sample_t DOUT_B; // output b
  int bad_count = 0; // mismatches seen
  int compares = 0; // comparisons made

  gco_regs uut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SAMPLE_A(SA), .SAMPLE_B(SB), .EXT_EST(EE), .DOUT_A(DOUT_A), .DOUT_B(DOUT_B));

  // clock: invert every half period of 50 ns
  always #50 CLK = ~CLK;

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  // one-cycle write strobe
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  // read, then look at the answer in the only cycle it stands
  task automatic rdchk(input string nm, input logic [8:0] a, input logic [7:0] e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    `CHK(nm, e, RDATA)
  endtask : rdchk

  // hold both samples long enough for the two-stage path to fill
  task automatic settle(input int a, input int b, input int n);
    @(posedge CLK);
    SA <= 16'(a);
    SB <= 16'(b);
    repeat (n) @(posedge CLK);
    #1;
  endtask : settle

  // an unknown output never counts as near
  function automatic logic near(input gco_pkg::gco_sample_t g, input int e, input int tol);
    int d;
    if ($isunknown(g)) begin
      return 1'b0;
    end
    d = int'(g) - e;
    return (d <= tol) && (d >= -tol);
  endfunction : near

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every register clears on reset; unmapped reads give zero
  task automatic t_reset;
    rdchk("est_rst", `GCO_ADDR_EST_SRC_A, 8'h00);
    rdchk("ctla_rst", `GCO_ADDR_CTRL_A, 8'h00);
    rdchk("ctlb_rst", `GCO_ADDR_CTRL_B, 8'h00);
    rdchk("gain_rst", `GCO_ADDR_GAIN, 8'h00);
    rdchk("unmapped", 9'h1ff, 8'h00);
  endtask : t_reset

  // legal register writes (reserved bits zero, keep bits set) plus one unmapped write; channel b stays apart
  task automatic t_regs;
    wr(`GCO_ADDR_GAIN, 8'h0b);
    rdchk("gain_rb", `GCO_ADDR_GAIN, 8'h0b);
    wr(`GCO_ADDR_EST_SRC_A, 8'h01);
    rdchk("est_rb", `GCO_ADDR_EST_SRC_A, 8'h01);
    wr(`GCO_ADDR_CTRL_A, 8'ha6);
    rdchk("ctla_rb", `GCO_ADDR_CTRL_A, 8'ha6);
    rdchk("ctlb_sep", `GCO_ADDR_CTRL_B, 8'h00);
    rdchk("status", `GCO_ADDR_STATUS, 8'h05);
    wr(9'h1ff, 8'hff);
    rdchk("unmap_wr", 9'h1ff, 8'h00);
    wr(`GCO_ADDR_EST_SRC_A, 8'h00);
    wr(`GCO_ADDR_CTRL_A, 8'h26);
    wr(`GCO_ADDR_CTRL_B, 8'h26);
    rdchk("status_b", `GCO_ADDR_STATUS, 8'h03);
  endtask : t_regs

  // every defined gain code with the corrector bypassed, then saturation
  task automatic t_gain;
    int e;
    for (int c = 0; c < 12; c++) begin
      wr(`GCO_ADDR_GAIN, 8'(c));
      e = (1000 * $rtoi(16384.0 * 10.0 ** (c / 20.0) + 0.5)) >>> 14;
      settle(1000, -1000, 4);
      `CHK("gain_a", 1'b1, near(DOUT_A, e, 1))
      `CHK("gain_b", 1'b1, near(DOUT_B, -e, 1))
    end
    wr(`GCO_ADDR_GAIN, 8'h0b);
    settle(16'sh7000, -16'sh7000, 4);
    `CHK("sat_hi", 16'sh7fff, DOUT_A)
    `CHK("sat_lo", 16'sh8000, DOUT_B)
    wr(`GCO_ADDR_GAIN, 8'h00);
  endtask : t_gain

  // external estimate replaces the internal one on channel a
  task automatic t_ext;
    EE <= 16'sd100;
    wr(`GCO_ADDR_CTRL_A, 8'h22);
    wr(`GCO_ADDR_EST_SRC_A, 8'h01);
    settle(500, 500, 4);
    `CHK("ext_a", 16'sd400, DOUT_A)
    `CHK("byp_b", 16'sd500, DOUT_B)
    wr(`GCO_ADDR_EST_SRC_A, 8'h00);
  endtask : t_ext

  // offset learned and removed, then frozen, then bypassed
  task automatic t_dc;
    settle(1000, 1000, 4000);
    `CHK("dc_gone", 1'b1, near(DOUT_A, 0, 8))
    `CHK("dc_b_kept", 16'sd1000, DOUT_B)
    wr(`GCO_ADDR_CTRL_A, 8'ha2);
    settle(2000, 2000, 1000);
    `CHK("frozen", 1'b1, near(DOUT_A, 1000, 8))
    wr(`GCO_ADDR_CTRL_A, 8'ha6);
    settle(2000, 2000, 4);
    `CHK("bypass", 16'sd2000, DOUT_A)
  endtask : t_dc

  // a period-8 pattern holds tones at fs/8 to fs/2; each phase learns its own level
  task automatic t_tone;
    int v;
    wr(`GCO_ADDR_CTRL_A, 8'h22);
    for (int k = 0; k < 4008; k++) begin
      v = ((k % 2) != 0) ? -500 : 500;
      v = v + (((k % 8) < 4) ? 300 : -300) + (((k % 4) < 2) ? 200 : -200);
      @(posedge CLK);
      SA <= 16'(v);
      if (k >= 4000) begin
        #1;
        `CHK("tone_gone", 1'b1, near(DOUT_A, 0, 8))
      end
    end
  endtask : t_tone

  // ----------------------------------------
  // verdict, main sequence and watchdog
  // ----------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d of %0d comparisons", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_regs();
    t_gain();
    t_ext();
    t_dc();
    t_tone();
    print_verdict();
  end

  // watchdog: whole run needs just over 9000 cycles
  initial begin
    repeat (20000) @(posedge CLK);
    bad_count++;
    print_verdict();
  end
endmodule : tb
